// ---- hdl/lfc_pkg.sv ----
// shared constants and types for the laser fault and identification control block
package lfc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_FAULT_OFF_US = 100;
  localparam int FAULT_OFF_CYC = T_FAULT_OFF_US * CLK_MHZ;
  localparam int T_LASER_ON_US = 1000;
  localparam int LASER_ON_CYC = T_LASER_ON_US * CLK_MHZ;
  localparam int T_LOCK_WINDOW_MS = 25;
  localparam int LOCK_WINDOW_CYC = T_LOCK_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int WIN_W = 23;

  // ----------------------------------------
  // identification link
  // ----------------------------------------
  localparam logic [7:0] CTRL_SET_ADDR = 8'hA0;
  localparam logic [7:0] CTRL_READ = 8'hA1;
  localparam int ROM_DEPTH = 128;
  localparam logic [7:0] ROM_SEED = 8'h5A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] NEXT_BYTE_MARK = 4'h9;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [6:0] PTR_RST = 7'h00;

  typedef enum logic [1:0] {LAS_OFF, LAS_ON, LAS_FAULT, LAS_LOCK} lfc_las_t;

  typedef enum logic [2:0] {I_IDLE, I_DEV, I_DEV_ACK, I_ADDR, I_ADDR_ACK, I_SKIP, I_TX, I_TX_ACK} lfc_link_t;

  typedef struct packed {
    lfc_las_t las;
    logic fault;
    logic [WIN_W-1:0] win;
    logic req_q;
    logic los;
    lfc_link_t ist;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [6:0] ptr;
    logic rd;
    logic sda_oe;
  } lfc_state_t;

endpackage

// ---- hdl/lfc_top.sv ----
// laser fault control, loss-of-light flag and read-only identification memory
// Contract
// RULE_01: loss flag high while light too low
// RULE_02: power fault raises fault flag, laser off; code acts on power_fault_i only in LAS_ON and ignores it in LAS_OFF
// RULE_03: laser off within 100 us of fault
// RULE_04: off request removes modulation and bias power
// RULE_05: request low, no fault: laser on within 1ms
// RULE_06: request pulse clears fault and retries laser
// RULE_07: refault within 25 ms locks fault high
// RULE_08: lock clears only at power-on reset
// RULE_09: host opens access with start condition
// RULE_10: host sends address-set control byte first
// RULE_11: host changes data only while clock low
// RULE_12: device acknowledges control and address bytes
// RULE_13: address top bit ignored for read pointer
// RULE_14: host repeated start, then read control byte
// RULE_15: host acknowledges byte or ends transfer
// RULE_16: host closes access with stop condition
// RULE_17: identification memory holds 128 bytes
// RULE_18: identification memory cannot be written
// RULE_19: host holds request high at least 10 us
// RULE_20: read pointer steps after each sent byte
`timescale 1ns/1ps
module lfc_top #(
  parameter logic [lfc_pkg::WIN_W-1:0] LOCK_WIN_CYC = lfc_pkg::WIN_W'(lfc_pkg::LOCK_WINDOW_CYC)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic light_low_i,
  input wire logic power_fault_i,
  input wire logic laser_off_req_i,
  input wire logic ident_clock_pin_i,
  input wire logic ident_data_pin_i,
  output logic ident_data_pin_o,
  output logic ident_data_pin_oe_o,
  output logic receive_light_lost_o,
  output logic tx_fault_o,
  output logic laser_mod_en_o,
  output logic laser_bias_en_o
);

  lfc_pkg::lfc_state_t st_ff;
  lfc_pkg::lfc_state_t nxt_st;
  logic [7:0] id_rom [lfc_pkg::ROM_DEPTH];
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rom_byte;

  // ----------------------------------------
  // identification memory, constant contents
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < lfc_pkg::ROM_DEPTH; gi++)
    begin : g_rom
      assign id_rom[gi] = 8'(gi) ^ lfc_pkg::ROM_SEED; // RULE_17 RULE_18
    end
  endgenerate

  assign rom_byte = id_rom[st_ff.ptr];
  assign scl_rise = ident_clock_pin_i & ~st_ff.scl_q;
  assign scl_fall = ~ident_clock_pin_i & st_ff.scl_q;
  assign start_cond = st_ff.scl_q & ident_clock_pin_i & st_ff.sda_q & ~ident_data_pin_i;
  assign stop_cond = st_ff.scl_q & ident_clock_pin_i & ~st_ff.sda_q & ident_data_pin_i;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.req_q = laser_off_req_i;
    nxt_st.los = light_low_i; // RULE_01
    nxt_st.scl_q = ident_clock_pin_i;
    nxt_st.sda_q = ident_data_pin_i;
    if (st_ff.win != '0)
    begin
      nxt_st.win = st_ff.win - lfc_pkg::WIN_W'(1);
    end
    unique case (st_ff.las)
      lfc_pkg::LAS_OFF:
      begin
        if (!laser_off_req_i)
        begin
          nxt_st.las = lfc_pkg::LAS_ON; // RULE_05
        end
      end
      lfc_pkg::LAS_ON:
      begin
        if (power_fault_i)
        begin
          nxt_st.fault = 1'b1; // RULE_02 RULE_03
          if (st_ff.win != '0)
          begin
            nxt_st.las = lfc_pkg::LAS_LOCK; // RULE_07
          end
          else
          begin
            nxt_st.las = lfc_pkg::LAS_FAULT;
          end
        end
        else if (laser_off_req_i)
        begin
          nxt_st.las = lfc_pkg::LAS_OFF; // RULE_04
        end
      end
      lfc_pkg::LAS_FAULT:
      begin
        if (st_ff.req_q && !laser_off_req_i)
        begin
          nxt_st.fault = 1'b0; // RULE_06
          nxt_st.las = lfc_pkg::LAS_ON;
          nxt_st.win = LOCK_WIN_CYC;
        end
      end
      lfc_pkg::LAS_LOCK:
      begin
        nxt_st.fault = 1'b1; // RULE_08
      end
    endcase

    // identification link slave
    if (start_cond)
    begin
      nxt_st.ist = lfc_pkg::I_DEV;
      nxt_st.cnt = 4'h0;
      nxt_st.sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      nxt_st.ist = lfc_pkg::I_IDLE;
      nxt_st.sda_oe = 1'b0;
    end
    else
    begin
      unique case (st_ff.ist)
        lfc_pkg::I_IDLE:
        begin
          nxt_st.sda_oe = 1'b0;
        end
        lfc_pkg::I_DEV, lfc_pkg::I_ADDR, lfc_pkg::I_SKIP:
        begin
          if (scl_rise && st_ff.cnt < lfc_pkg::BITS_PER_BYTE)
          begin
            nxt_st.sh = {st_ff.sh[6:0], ident_data_pin_i};
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end
          else if (scl_fall && st_ff.cnt == lfc_pkg::BITS_PER_BYTE)
          begin
            nxt_st.cnt = 4'h0;
            if (st_ff.ist == lfc_pkg::I_DEV)
            begin
              if (st_ff.sh == lfc_pkg::CTRL_SET_ADDR || st_ff.sh == lfc_pkg::CTRL_READ)
              begin
                nxt_st.rd = st_ff.sh[0];
                nxt_st.sda_oe = 1'b1; // RULE_12
                nxt_st.ist = lfc_pkg::I_DEV_ACK;
              end
              else
              begin
                nxt_st.ist = lfc_pkg::I_IDLE;
              end
            end
            else if (st_ff.ist == lfc_pkg::I_ADDR)
            begin
              nxt_st.ptr = st_ff.sh[6:0]; // RULE_13
              nxt_st.sda_oe = 1'b1; // RULE_12
              nxt_st.ist = lfc_pkg::I_ADDR_ACK;
            end
          end
        end
        lfc_pkg::I_DEV_ACK:
        begin
          if (scl_fall)
          begin
            nxt_st.cnt = 4'h0;
            if (st_ff.rd)
            begin
              nxt_st.ist = lfc_pkg::I_TX;
              nxt_st.sh = rom_byte;
              nxt_st.sda_oe = ~rom_byte[7];
            end
            else
            begin
              nxt_st.ist = lfc_pkg::I_ADDR;
              nxt_st.sda_oe = 1'b0;
            end
          end
        end
        lfc_pkg::I_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.ist = lfc_pkg::I_SKIP; // RULE_18
          end
        end
        lfc_pkg::I_TX:
        begin
          if (scl_rise)
          begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (st_ff.cnt == lfc_pkg::BITS_PER_BYTE)
            begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.cnt = 4'h0;
              nxt_st.ptr = st_ff.ptr + 7'h01; // RULE_20
              nxt_st.ist = lfc_pkg::I_TX_ACK;
            end
            else
            begin
              nxt_st.sh = {st_ff.sh[6:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.sh[6];
            end
          end
        end
        lfc_pkg::I_TX_ACK:
        begin
          if (scl_rise)
          begin
            if (ident_data_pin_i)
            begin
              nxt_st.ist = lfc_pkg::I_IDLE;
            end
            else
            begin
              nxt_st.cnt = lfc_pkg::NEXT_BYTE_MARK;
            end
          end
          else if (scl_fall && st_ff.cnt == lfc_pkg::NEXT_BYTE_MARK)
          begin
            nxt_st.cnt = 4'h0;
            nxt_st.sh = rom_byte;
            nxt_st.sda_oe = ~rom_byte[7];
            nxt_st.ist = lfc_pkg::I_TX;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '{las: lfc_pkg::LAS_OFF, fault: 1'b0, win: '0, req_q: 1'b1, los: 1'b1,
                 ist: lfc_pkg::I_IDLE, scl_q: 1'b1, sda_q: 1'b1, cnt: 4'h0, sh: 8'h00,
                 ptr: lfc_pkg::PTR_RST, rd: 1'b0, sda_oe: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign receive_light_lost_o = st_ff.los;
  assign tx_fault_o = st_ff.fault;
  assign laser_mod_en_o = (st_ff.las == lfc_pkg::LAS_ON); // RULE_04
  assign laser_bias_en_o = (st_ff.las == lfc_pkg::LAS_ON); // RULE_04
  assign ident_data_pin_o = 1'b0;
  assign ident_data_pin_oe_o = st_ff.sda_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence req_pulse_s;
    laser_off_req_i ##1 !laser_off_req_i;
  endsequence

  sequence quiet_low_s;
    (!laser_off_req_i && !tx_fault_o && !power_fault_i) [*3];
  endsequence

  los_follow_a: assert property (light_low_i |=> receive_light_lost_o == 1'b1) else $error("loss flag missed"); // RULE_01
  fault_flag_a: assert property (laser_mod_en_o && power_fault_i |=> tx_fault_o) else $error("fault not flagged"); // RULE_02
  fault_off_a: assert property (laser_mod_en_o && power_fault_i |=> !laser_mod_en_o && !laser_bias_en_o) else $error("laser stayed on"); // RULE_03
  off_req_a: assert property (laser_off_req_i |=> !laser_mod_en_o && !laser_bias_en_o) else $error("laser on while off requested"); // RULE_04
  laser_on_a: assert property (quiet_low_s |-> laser_mod_en_o) else $error("laser not turned on"); // RULE_05
  fault_reset_a: assert property ((st_ff.las == lfc_pkg::LAS_FAULT) ##0 req_pulse_s |=> !tx_fault_o && laser_mod_en_o) else $error("fault not reset"); // RULE_06
  lock_set_a: assert property (laser_mod_en_o && power_fault_i && st_ff.win != '0 |=> st_ff.las == lfc_pkg::LAS_LOCK) else $error("refault not locked"); // RULE_07
  lock_hold_a: assert property (st_ff.las == lfc_pkg::LAS_LOCK |=> tx_fault_o && !laser_mod_en_o && st_ff.las == lfc_pkg::LAS_LOCK) else $error("lock released"); // RULE_08
  ctrl_ack_a: assert property (st_ff.ist == lfc_pkg::I_DEV && scl_fall && !start_cond && !stop_cond && st_ff.cnt == lfc_pkg::BITS_PER_BYTE && st_ff.sh == lfc_pkg::CTRL_SET_ADDR |=> ident_data_pin_oe_o) else $error("control byte not acknowledged"); // RULE_12
  addr_ptr_a: assert property (st_ff.ist == lfc_pkg::I_ADDR && scl_fall && !start_cond && !stop_cond && st_ff.cnt == lfc_pkg::BITS_PER_BYTE |=> st_ff.ptr == $past(st_ff.sh[6:0])) else $error("pointer not loaded"); // RULE_13
  no_write_a: assert property (st_ff.ist == lfc_pkg::I_SKIP |-> !ident_data_pin_oe_o) else $error("write data acknowledged"); // RULE_18
  ptr_step_a: assert property (st_ff.ist == lfc_pkg::I_TX && scl_fall && !start_cond && !stop_cond && st_ff.cnt == lfc_pkg::BITS_PER_BYTE |=> st_ff.ptr == 7'($past(st_ff.ptr) + 7'h01)) else $error("pointer not stepped"); // RULE_20

endmodule

// ---- verif/lfc_host_model.sv ----
// two-wire host master model for the identification link
`timescale 1ns/1ps
module lfc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  initial
  begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // one phase: change lines after an edge, hold five cycles
  task automatic hp(input logic c, input logic p);
    @(posedge clk_i);
    scl_o <= c;
    pull_o <= p;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic xbit(input logic b, output logic r);
    hp(1'b0, ~b);
    hp(1'b1, ~b);
    r = sda_i;
    hp(1'b0, ~b);
  endtask
  task automatic start();
    hp(1'b0, 1'b0);
    hp(1'b1, 1'b0);
    hp(1'b1, 1'b1);
    hp(1'b0, 1'b1);
  endtask
  task automatic stop();
    hp(1'b0, 1'b1);
    hp(1'b1, 1'b1);
    hp(1'b1, 1'b0);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(~more, r);
  endtask
endmodule

// ---- verif/tb_lfc_top.sv ----
// self-checking bench for the laser fault and identification block
`timescale 1ns/1ps
module tb_lfc_top;
  logic clk_i, sys_rst_i, light_low_i, power_fault_i, laser_off_req_i;
  logic scl, pull, sda, d_o, d_oe, los, flt, mod_en, bias_en, ack;
  logic [7:0] rd;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  // open-drain data wire with pull-up
  assign sda = (d_oe ? d_o : 1'b1) & ~pull;
  lfc_top #(.LOCK_WIN_CYC(23'h0000C8)) i_lfc_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .light_low_i(light_low_i),
    .power_fault_i(power_fault_i), .laser_off_req_i(laser_off_req_i),
    .ident_clock_pin_i(scl), .ident_data_pin_i(sda), .ident_data_pin_o(d_o),
    .ident_data_pin_oe_o(d_oe), .receive_light_lost_o(los), .tx_fault_o(flt),
    .laser_mod_en_o(mod_en), .laser_bias_en_o(bias_en));
  lfc_host_model i_lfc_host_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  // ----
  // clock, timeout, helpers
  // ----
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic las(input logic f, input logic e);
    #1 chk("fault", 8'(flt), 8'(f));
    chk("mod", 8'(mod_en), 8'(e));
    chk("bias", 8'(bias_en), 8'(e));
  endtask
  task automatic hit();
    wt(1);
    power_fault_i <= 1'b1;
    wt(3);
    power_fault_i <= 1'b0;
  endtask
  task automatic tog();
    wt(1);
    laser_off_req_i <= 1'b1;
    wt(2000);
    laser_off_req_i <= 1'b0;
    wt(3);
  endtask
  task automatic point(input logic [7:0] a);
    i_lfc_host_model.start();
    i_lfc_host_model.wbyte(lfc_pkg::CTRL_SET_ADDR, ack);
    chk("ack", 8'(ack), 8'h01);
    i_lfc_host_model.wbyte(a, ack);
    chk("ack", 8'(ack), 8'h01);
    i_lfc_host_model.start();
    i_lfc_host_model.wbyte(lfc_pkg::CTRL_READ, ack);
    chk("ack", 8'(ack), 8'h01);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_las();
    wt(3);
    las(1'b0, 1'b1);
    #1 chk("loss", 8'(los), 8'h00);
    wt(1);
    light_low_i <= 1'b1;
    laser_off_req_i <= 1'b1;
    wt(3);
    #1 chk("loss", 8'(los), 8'h01);
    las(1'b0, 1'b0);
    wt(1);
    light_low_i <= 1'b0;
    laser_off_req_i <= 1'b0;
    wt(3);
    las(1'b0, 1'b1);
  endtask
  task automatic t_fault();
    hit();
    las(1'b1, 1'b0);
    tog();
    las(1'b0, 1'b1);
    wt(250);
    hit();
    tog();
    las(1'b0, 1'b1);
    wt(10);
    hit();
    las(1'b1, 1'b0);
    tog();
    las(1'b1, 1'b0);
    wt(1);
    sys_rst_i <= 1'b1;
    wt(2);
    sys_rst_i <= 1'b0;
    wt(3);
    las(1'b0, 1'b1);
  endtask
  task automatic t_id();
    point(8'hFE);
    for (int i = 0; i < 3; i++)
    begin
      i_lfc_host_model.rbyte(i < 2, rd);
      chk("data", rd, {1'b0, 7'(7'h7E + 7'(i))} ^ lfc_pkg::ROM_SEED);
    end
    i_lfc_host_model.stop();
    i_lfc_host_model.start();
    i_lfc_host_model.wbyte(lfc_pkg::CTRL_SET_ADDR, ack);
    i_lfc_host_model.wbyte(8'h10, ack);
    i_lfc_host_model.wbyte(8'hFF, ack);
    chk("wr ack", 8'(ack), 8'h00);
    i_lfc_host_model.stop();
    i_lfc_host_model.start();
    i_lfc_host_model.wbyte(8'hA2, ack);
    chk("bad ack", 8'(ack), 8'h00);
    i_lfc_host_model.stop();
    point(8'h10);
    i_lfc_host_model.rbyte(1'b0, rd);
    chk("data", rd, 8'h10 ^ lfc_pkg::ROM_SEED);
    i_lfc_host_model.stop();
  endtask
  initial
  begin
    sys_rst_i = 1'b1;
    light_low_i = 1'b0;
    power_fault_i = 1'b0;
    laser_off_req_i = 1'b0;
    wt(4);
    #1 chk("loss", 8'(los), 8'h01);
    las(1'b0, 1'b0);
    wt(1);
    sys_rst_i <= 1'b0;
    t_las();
    t_fault();
    t_id();
    conclude();
  end
endmodule
